// ===== verilog/asft_map.vh
// Constants for the asynchronous serial frame transmitter
`ifndef ASFT_MAP_VH
`define ASFT_MAP_VH
// Oversampling divider ahead of the coarse and power-of-two stages
`define ASFT_OVERSAMPLE 16
// Coarse divider select codes
`define ASFT_PR_SEL_1 2'h0
`define ASFT_PR_SEL_3 2'h1
`define ASFT_PR_SEL_4 2'h2
`define ASFT_PR_SEL_13 2'h3
// Frame shapes
`define ASFT_KIND_DATA 2'h0
`define ASFT_KIND_IDLE 2'h1
`define ASFT_KIND_BREAK 2'h2
`define ASFT_KIND_MARK 2'h3
// Bit counts per frame, start and stop included
`define ASFT_FRAME_BITS_8 4'hA
`define ASFT_FRAME_BITS_9 4'hB
// Reset values
`define ASFT_RST_EMPTY 1'h1
`define ASFT_RST_COMPLETE 1'h0
`endif

// ===== verilog/asft_baud_gen.v
// Transmit bit-period tick generator
`timescale 1ns/1ns
`include "asft_map.vh"
module asft_baud_gen #(
  parameter CW = 16
) (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Rate selection and control
  input wire run_i,
  input wire [1:0] coarse_sel_i,
  input wire [2:0] rate_factor_i,
  // One-cycle tick per bit period
  output reg tick_o
);
  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  reg [CW-1:0] cnt_q;
  reg [3:0] coarse;
  wire [31:0] limit_full;
  wire [CW-1:0] limit;

  // Coarse stage selection
  always @* begin
    case (coarse_sel_i)
      `ASFT_PR_SEL_1: coarse = 4'h1;
      `ASFT_PR_SEL_3: coarse = 4'h3;
      `ASFT_PR_SEL_4: coarse = 4'h4;
      default: coarse = 4'hD;
    endcase
  end

  // One counter spans all stages; fine for transmit, where no phase matters
  assign limit_full = ({28'h0000000, coarse} * `ASFT_OVERSAMPLE << rate_factor_i) - 32'h1;
  // Largest product fits the default width; cut on purpose
  assign limit = limit_full[CW-1:0];

  // Own counter, independent of any receive timing
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= {CW{1'b0}};
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= {CW{1'b0}};
      tick_o <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= {CW{1'b0}};
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ===== verilog/asft_top.v
// Transmit side of the asynchronous serial interface
`timescale 1ns/1ns
`include "asft_map.vh"
// Operation
// - Enabled and idle: output held high
// - Both disabled: pin returned to port
// - Start, 8/9 data LSB first, stop
// - Word-length bit picks 8 or 9
// - Start bit low, stop bit high
// - Idle frame is all ones
// - Break is zero frames plus one mark
// - Transmit rate from its own divider
// - Ninth bit sent as MSB
// - Enabling sends one idle frame first
// - Empty flag cleared by status-then-data sequence
// - Empty flag requests interrupt when enabled
// - Busy write goes to holding buffer
// - Idle write loads shifter, sets empty
// - Frame end sets complete, requests interrupt
// - Complete cleared by same sequence
// - Break repeats while set, then mark
// - Enable toggle: idle after word, buffer lost
module asft_top #(
  parameter CW = 16
) (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Software access strobes and data
  input wire status_rd_i,
  input wire data_wr_i,
  input wire [7:0] data_i,
  // Control bits
  input wire tx_enable_i,
  input wire rx_enable_i,
  input wire word9_i,
  input wire tx_ninth_bit_i,
  input wire send_break_i,
  input wire tx_empty_irq_enable_i,
  input wire tx_done_irq_enable_i,
  input wire cpu_irq_mask_i,
  input wire [1:0] baud_coarse_divider_i,
  input wire [2:0] tx_rate_factor_i,
  // Status and interrupt
  output reg tx_buffer_empty_o,
  output reg tx_complete_o,
  output reg irq_o,
  // Serial pin
  output reg serial_tx_o,
  output reg serial_tx_oe_n_o
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg state_q;
  reg [1:0] kind_q;
  reg [10:0] shift_q;
  reg [3:0] bits_q;
  reg [8:0] hold_q;
  reg hold_full_q;
  reg armed_q;
  reg idle_pend_q;
  reg brk_seen_q;
  reg te_q;
  wire tick;
  wire pin_on;
  wire seq_wr;
  wire [3:0] nbits;

  assign pin_on = tx_enable_i | rx_enable_i;
  assign nbits = word9_i ? `ASFT_FRAME_BITS_9 : `ASFT_FRAME_BITS_8;
  assign seq_wr = data_wr_i & armed_q;

  asft_baud_gen #(.CW(CW)) u_baud (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .run_i(state_q),
    .coarse_sel_i(baud_coarse_divider_i),
    .rate_factor_i(tx_rate_factor_i),
    .tick_o(tick)
  );

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  // Next frame priority: break, trailing mark, pending idle, held data
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      kind_q <= `ASFT_KIND_DATA;
      shift_q <= 11'h7FF;
      bits_q <= 4'h0;
      hold_q <= 9'h000;
      hold_full_q <= 1'b0;
      armed_q <= 1'b0;
      idle_pend_q <= 1'b0;
      brk_seen_q <= 1'b0;
      te_q <= 1'b0;
      tx_buffer_empty_o <= `ASFT_RST_EMPTY;
      tx_complete_o <= `ASFT_RST_COMPLETE;
      irq_o <= 1'b0;
      serial_tx_o <= 1'b1;
      serial_tx_oe_n_o <= 1'b1;
    end else begin
      te_q <= tx_enable_i;
      // Status read arms clearing; data write completes it
      if (status_rd_i)
        armed_q <= 1'b1;
      else if (data_wr_i)
        armed_q <= 1'b0;
      // Enable rising: queue idle frame, drop held data
      if (tx_enable_i & ~te_q) begin
        idle_pend_q <= 1'b1;
        hold_full_q <= 1'b0;
      end
      // Pin drive: high when on and idle, released when both off
      serial_tx_oe_n_o <= ~pin_on;
      // Stay low between back-to-back break frames so the break has no glitch
      if (state_q == ST_IDLE)
        serial_tx_o <= ~(tx_enable_i & send_break_i);
      else
        serial_tx_o <= shift_q[0];
      case (state_q)
        ST_IDLE: begin
          if (tx_enable_i & send_break_i) begin
            state_q <= ST_SEND;
            kind_q <= `ASFT_KIND_BREAK;
            shift_q <= 11'h000;
            bits_q <= nbits;
            brk_seen_q <= 1'b1;
          end else if (tx_enable_i & brk_seen_q) begin
            state_q <= ST_SEND;
            kind_q <= `ASFT_KIND_MARK;
            shift_q <= 11'h7FF;
            bits_q <= 4'h1;
            brk_seen_q <= 1'b0;
          end else if (tx_enable_i & (idle_pend_q | (tx_enable_i & ~te_q))) begin
            state_q <= ST_SEND;
            kind_q <= `ASFT_KIND_IDLE;
            shift_q <= 11'h7FF;
            bits_q <= nbits;
            idle_pend_q <= 1'b0;
          end else if (tx_enable_i & (hold_full_q | data_wr_i)) begin
            state_q <= ST_SEND;
            kind_q <= `ASFT_KIND_DATA;
            // Start low, data LSB first, ninth bit, stop high
            if (word9_i)
              shift_q <= {1'b1, (data_wr_i & ~hold_full_q) ? tx_ninth_bit_i : hold_q[8],
                (data_wr_i & ~hold_full_q) ? data_i : hold_q[7:0], 1'b0};
            else
              shift_q <= {2'b11, (data_wr_i & ~hold_full_q) ? data_i : hold_q[7:0],
                1'b0};
            bits_q <= nbits;
            hold_full_q <= 1'b0;
            tx_buffer_empty_o <= 1'b1;
          end
        end
        ST_SEND: begin
          if (tick) begin
            shift_q <= {1'b1, shift_q[10:1]};
            bits_q <= bits_q - 1'b1;
            if (bits_q == 4'h1) begin
              state_q <= ST_IDLE;
              if (kind_q != `ASFT_KIND_MARK)
                tx_complete_o <= 1'b1;
            end
          end
          // Write during a frame lands in the holding buffer
          if (data_wr_i) begin
            hold_q <= {tx_ninth_bit_i, data_i};
            hold_full_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      // Sequence clears flags; hardware set above wins the same cycle
      if (seq_wr & ~(state_q == ST_IDLE & tx_enable_i & ~send_break_i & ~brk_seen_q
          & ~idle_pend_q & ~(tx_enable_i & ~te_q)))
        tx_buffer_empty_o <= 1'b0;
      if (seq_wr & ~(state_q == ST_SEND & tick & bits_q == 4'h1 & kind_q != `ASFT_KIND_MARK))
        tx_complete_o <= 1'b0;
      // Interrupt request from both transmit flags
      irq_o <= ~cpu_irq_mask_i & ((tx_buffer_empty_o & tx_empty_irq_enable_i)
        | (tx_complete_o & tx_done_irq_enable_i));
    end
  end
endmodule

// ===== test/asft_top_asserts.sv
// Port assertions for the serial frame transmitter
`timescale 1ns/1ns
module asft_top_asserts (
  // Watched ports
  input wire mclk_i,
  input wire arst_n_i,
  input wire data_wr_i,
  input wire tx_enable_i,
  input wire rx_enable_i,
  input wire send_break_i,
  input wire tx_empty_irq_enable_i,
  input wire tx_done_irq_enable_i,
  input wire cpu_irq_mask_i,
  input wire [1:0] baud_coarse_divider_i,
  input wire [2:0] tx_rate_factor_i,
  input wire tx_buffer_empty_o,
  input wire tx_complete_o,
  input wire irq_o,
  input wire serial_tx_o,
  input wire serial_tx_oe_n_o
);
  // --
  // Properties
  // --
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  AST_RST_FLAGS: assert property ($rose(arst_n_i) |-> tx_buffer_empty_o && !tx_complete_o)
    else $error("flags wrong after reset");
  AST_OE_ON: assert property (tx_enable_i || rx_enable_i |=> !serial_tx_oe_n_o)
    else $error("pin not driven");
  AST_OE_OFF: assert property (!tx_enable_i && !rx_enable_i |=> serial_tx_oe_n_o)
    else $error("pin not released");
  AST_IRQ: assert property (1 |=> irq_o == $past(!cpu_irq_mask_i &&
    (tx_buffer_empty_o && tx_empty_irq_enable_i || tx_complete_o && tx_done_irq_enable_i)))
    else $error("irq mismatch");
  AST_EMPTY_CLR: assert property ($fell(tx_buffer_empty_o) |-> $past(data_wr_i))
    else $error("empty cleared without write");
  AST_DONE_CLR: assert property ($fell(tx_complete_o) |-> $past(data_wr_i))
    else $error("complete cleared without write");
  AST_STOP_HIGH: assert property ($rose(tx_complete_o) && !send_break_i &&
    !$past(send_break_i, 200) |-> serial_tx_o)
    else $error("frame ended low");
  // Any low bit lasts at least half a period at the fastest rate
  AST_LOW_RUN: assert property ($fell(serial_tx_o) && baud_coarse_divider_i == 2'h0 &&
    tx_rate_factor_i == 3'h0 |-> !serial_tx_o [*8])
    else $error("short low bit");
endmodule
bind asft_top asft_top_asserts chk_u (.*);

// ===== test/asft_line_model.sv
// Far-end receiver model sampling the serial line
`timescale 1ns/1ns
module asft_line_model #(
  parameter BIT = 16
) (
  // Line side
  input wire mclk_i,
  input wire line_i,
  input wire word9_i,
  // Captured frame
  output reg [8:0] word_o,
  output reg [7:0] count_o,
  output reg stop_o
);
  integer i;
  // Mid-bit sampling; idle frames carry no start bit
  initial begin
    word_o = 9'h000;
    count_o = 8'h00;
    stop_o = 1'b1;
    forever begin
      @(negedge line_i);
      repeat (BIT / 2) @(posedge mclk_i);
      if (!line_i) begin
        for (i = 0; i < 8 + word9_i; i = i + 1) begin
          repeat (BIT) @(posedge mclk_i);
          word_o[i] = line_i;
        end
        if (!word9_i)
          word_o[8] = 1'b0;
        repeat (BIT) @(posedge mclk_i);
        stop_o = line_i;
        count_o = count_o + 8'h01;
      end
    end
  end
endmodule

// ===== test/test_asft_top.sv
// Self-checking bench for the serial frame transmitter
`timescale 1ns/1ns
module test_asft_top;
  // --
  // Stimulus and observation
  // --
  reg mclk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg rd = 1'b0, wr = 1'b0, te = 1'b0, w9 = 1'b0, t8 = 1'b0, send_break = 1'b0, tx_empty_irq_enable = 1'b0, msk = 1'b0;
  reg tx_done_irq_enable = 1'b0;
  reg [7:0] din = 8'h00;
  wire emp, done, irq, txd, oe_n, stop;
  wire [8:0] word;
  wire [7:0] cnt;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  // Clock, 8 ns period
  always #4 mclk_i = ~mclk_i;
  asft_top dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .status_rd_i(rd), .data_wr_i(wr),
    .data_i(din), .tx_enable_i(te), .rx_enable_i(1'b0), .word9_i(w9), .tx_ninth_bit_i(t8),
    .send_break_i(send_break), .tx_empty_irq_enable_i(tx_empty_irq_enable), .tx_done_irq_enable_i(tx_done_irq_enable),
    .cpu_irq_mask_i(msk), .baud_coarse_divider_i(2'h0), .tx_rate_factor_i(3'h0),
    .tx_buffer_empty_o(emp), .tx_complete_o(done), .irq_o(irq), .serial_tx_o(txd),
    .serial_tx_oe_n_o(oe_n));
  asft_line_model peer_u (.mclk_i(mclk_i), .line_i(txd), .word9_i(w9), .word_o(word),
    .count_o(cnt), .stop_o(stop));
  // --
  // Helpers
  // --
  task check(input [79:0] what, input [8:0] exp, input [8:0] seen);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk_i);
  endtask
  // Optional status access, then one data write
  task send(input rdf, input [7:0] d);
    begin
      rd = rdf;
      cyc(1);
      rd = 1'b0;
      din = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
    end
  endtask
  task print_verdict;
    begin
      if (n_mismatch == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // --
  // Scenarios
  // --
  task sc_enable;
    reg lo;
    begin
      check("rst_oe", 1, oe_n);
      check("rst_emp", 1, emp);
      te = 1'b1;
      lo = 1'b0;
      repeat (150) begin
        cyc(1);
        lo = lo | (txd !== 1'b1);
      end
      check("idle_lo", 0, lo);
      cyc(20);
      check("idle_cnt", 0, cnt);
      check("oe_on", 0, oe_n);
    end
  endtask
  // Idle write, then a buffered write and an unread write
  task sc_bytes;
    begin
      send(1'b1, 8'hA5);
      check("emp_idle", 1, emp);
      send(1'b1, 8'h3C);
      check("emp_held", 0, emp);
      cyc(160);
      check("first", 9'h0A5, word);
      cyc(200);
      check("second", 9'h03C, word);
      check("done", 1, done);
      send(1'b0, 8'h0F);
      check("no_rd", 1, done);
      tx_empty_irq_enable = 1'b1;
      cyc(3);
      check("irq_on", 1, irq);
      msk = 1'b1;
      cyc(3);
      check("irq_msk", 0, irq);
      tx_empty_irq_enable = 1'b0;
      msk = 1'b0;
      tx_done_irq_enable = 1'b1;
      cyc(3);
      check("irq_done", 1, irq);
      tx_done_irq_enable = 1'b0;
      cyc(167);
      check("unread", 9'h00F, word);
    end
  endtask
  // Nine-bit frame, then break and its closing mark
  task sc_nine_break;
    begin
      w9 = 1'b1;
      t8 = 1'b1;
      send(1'b1, 8'h55);
      cyc(190);
      check("ninth", 9'h155, word);
      check("stop9", 1, stop);
      w9 = 1'b0;
      send_break = 1'b1;
      cyc(340);
      check("brk", 0, stop);
      send_break = 1'b0;
      cyc(220);
      check("mark", 1, txd);
      te = 1'b0;
      cyc(3);
      check("oe_off", 1, oe_n);
    end
  endtask
  // Main sequence
  initial begin
    cyc(6);
    arst_n_i = 1'b1;
    sc_enable;
    sc_bytes;
    sc_nine_break;
    print_verdict;
  end
  // Watchdog, well past the expected run
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
endmodule
